// [dac_trig_pkg.sv]
`default_nettype none
package dac_trig_pkg;
  localparam logic [7:0]  OUT_CODE_ADDR  = 8'h21;
  localparam logic [7:0]  UPPER_ADDR     = 8'h25;
  localparam logic [7:0]  LOWER_ADDR     = 8'h26;
  localparam logic [7:0]  TRIG_ADDR      = 8'hd3;
  localparam logic [15:0] TRIG_RESET     = 16'h0008;
  localparam int          CODE_MSB       = 11;
  localparam int          UNLOCK_MSB     = 15;
  localparam int          UNLOCK_LSB     = 12;
  localparam int          CFG_RESET_BIT  = 9;
  localparam int          RUN_BIT        = 8;
  localparam int          MARGIN_HI_BIT  = 7;
  localparam int          MARGIN_LO_BIT  = 6;
  localparam int          RECALL_BIT     = 5;
  localparam int          SAVE_BIT       = 4;
  localparam int          SWRST_MSB      = 3;
  localparam logic [3:0]  UNLOCK_KEY     = 4'h5;
  localparam logic [3:0]  SWRST_IDLE     = 4'h8;
  localparam logic [3:0]  SWRST_GO       = 4'ha;
  localparam logic [1:0]  SHAPE_TRIANGLE = 2'h0;
  localparam logic [1:0]  SHAPE_SAW_UP   = 2'h1;
  localparam logic [1:0]  SHAPE_SAW_DOWN = 2'h2;
  localparam logic [1:0]  SHAPE_SQUARE   = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_RECALL, ST_SAVE} store_op_t;
endpackage
`default_nettype wire

// [dac_trigger_and_code_regs.sv]
`default_nettype none
module dac_trigger_and_code_regs #(
  parameter int CODE_W = 10
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  output logic      [15:0]       rdata,
  input  wire logic              lock_in,
  input  wire logic [1:0]        waveform_shape_select,
  input  wire logic [15:0]       step_cycles,
  input  wire logic              store_done,
  input  wire logic [CODE_W-1:0] store_out_code,
  input  wire logic [CODE_W-1:0] store_upper_code,
  input  wire logic [CODE_W-1:0] store_lower_code,
  output logic                   store_recall_trigger,
  output logic                   store_save_trigger,
  output logic                   store_busy_flag,
  output logic                   lock_clear,
  output logic                   defaults_load,
  output logic      [CODE_W-1:0] active_code,
  output logic      [CODE_W-1:0] upper_code,
  output logic      [CODE_W-1:0] lower_code
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic                    bypass_r;
  logic                    waveform_run_bit;
  logic                    margin_hi_r;
  logic                    margin_lo_r;
  logic                    dir_up_r;
  logic [15:0]             timer_r;
  dac_trig_pkg::store_op_t op_r;
  logic                    locked;
  logic                    wr_ok;
  logic                    wr_trig;
  logic                    cfg_rst;
  logic                    sw_rst;
  logic                    defaults;
  logic                    tick;
  logic                    recall_go;
  logic                    save_go;
  logic [CODE_W-1:0]       wcode;

  assign locked   = lock_in && !bypass_r;
  assign wr_ok    = wr_en && !locked;
  assign wr_trig  = wr_ok && (addr == dac_trig_pkg::TRIG_ADDR);
  assign cfg_rst  = wr_trig && wdata[dac_trig_pkg::CFG_RESET_BIT];
  assign sw_rst   = wr_trig &&
                    (wdata[dac_trig_pkg::SWRST_MSB:0] == dac_trig_pkg::SWRST_GO);
  assign defaults = cfg_rst || sw_rst;
  // Narrow parts drop bits 3:2 by taking only the top of the field
  assign wcode    = wdata[dac_trig_pkg::CODE_MSB -: CODE_W];
  assign tick     = (timer_r == 16'h0000);
  assign recall_go = (op_r == dac_trig_pkg::ST_IDLE) &&
                     (sw_rst || (wr_trig && wdata[dac_trig_pkg::RECALL_BIT]));
  assign save_go   = (op_r == dac_trig_pkg::ST_IDLE) && !recall_go && !defaults &&
                     wr_trig && wdata[dac_trig_pkg::SAVE_BIT];

  // ------------------------------------------------------------
  // Unlock path
  // ------------------------------------------------------------
  // The key is honoured even while locked; it is the only way out
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      bypass_r   <= 1'b0;
      lock_clear <= 1'b0;
    end
    else
    begin
      lock_clear <= wr_en && (addr == dac_trig_pkg::TRIG_ADDR) &&
                    (wdata[dac_trig_pkg::UNLOCK_MSB:dac_trig_pkg::UNLOCK_LSB] ==
                     dac_trig_pkg::UNLOCK_KEY);
      if (wr_en && (addr == dac_trig_pkg::TRIG_ADDR) &&
          (wdata[dac_trig_pkg::UNLOCK_MSB:dac_trig_pkg::UNLOCK_LSB] == dac_trig_pkg::UNLOCK_KEY))
        bypass_r <= 1'b1;
      else if (!lock_in)
        bypass_r <= 1'b0;
    end

  // ------------------------------------------------------------
  // Trigger bits
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      waveform_run_bit <= 1'b0;
      margin_hi_r      <= 1'b0;
      margin_lo_r      <= 1'b0;
      defaults_load    <= 1'b0;
    end
    else
    begin
      defaults_load <= defaults;
      if (defaults)
      begin
        waveform_run_bit <= 1'b0;
        margin_hi_r      <= 1'b0;
        margin_lo_r      <= 1'b0;
      end
      else
      begin
        if (wr_trig)
          waveform_run_bit <= wdata[dac_trig_pkg::RUN_BIT];
        // Set wins over the arrival clear
        if (wr_trig && wdata[dac_trig_pkg::MARGIN_HI_BIT])
          margin_hi_r <= 1'b1;
        else if (active_code == upper_code)
          margin_hi_r <= 1'b0;
        if (wr_trig && wdata[dac_trig_pkg::MARGIN_LO_BIT])
          margin_lo_r <= 1'b1;
        else if (active_code == lower_code)
          margin_lo_r <= 1'b0;
      end
    end

  // ------------------------------------------------------------
  // Store operations
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      op_r                 <= dac_trig_pkg::ST_IDLE;
      store_busy_flag      <= 1'b0;
      store_recall_trigger <= 1'b0;
      store_save_trigger   <= 1'b0;
    end
    else
    begin
      store_recall_trigger <= recall_go;
      store_save_trigger   <= save_go;
      case (op_r)
        dac_trig_pkg::ST_IDLE:
          if (recall_go)
          begin
            op_r            <= dac_trig_pkg::ST_RECALL;
            store_busy_flag <= 1'b1;
          end
          else if (save_go)
          begin
            op_r            <= dac_trig_pkg::ST_SAVE;
            store_busy_flag <= 1'b1;
          end
        default:
          if (store_done)
          begin
            op_r            <= dac_trig_pkg::ST_IDLE;
            store_busy_flag <= 1'b0;
          end
      endcase
    end

  // ------------------------------------------------------------
  // Step timer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      timer_r <= 16'h0000;
    else if (tick || defaults)
      timer_r <= step_cycles;
    else
      timer_r <= timer_r - 16'h0001;

  // ------------------------------------------------------------
  // Level codes
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      upper_code <= '0;
      lower_code <= '0;
    end
    else if (defaults)
    begin
      upper_code <= '0;
      lower_code <= '0;
    end
    else if (op_r == dac_trig_pkg::ST_RECALL && store_done)
    begin
      upper_code <= store_upper_code;
      lower_code <= store_lower_code;
    end
    else if (wr_ok && addr == dac_trig_pkg::UPPER_ADDR)
      upper_code <= wcode;
    else if (wr_ok && addr == dac_trig_pkg::LOWER_ADDR)
      lower_code <= wcode;

  // ------------------------------------------------------------
  // Active code and waveform
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      active_code <= '0;
      dir_up_r    <= 1'b1;
    end
    else if (defaults)
    begin
      active_code <= '0;
      dir_up_r    <= 1'b1;
    end
    else if (op_r == dac_trig_pkg::ST_RECALL && store_done)
      active_code <= store_out_code;
    else if (wr_ok && addr == dac_trig_pkg::OUT_CODE_ADDR)
      active_code <= wcode;
    else if (tick && margin_hi_r && active_code != upper_code)
      active_code <= (active_code < upper_code) ? active_code + 1'b1
                                                : active_code - 1'b1;
    else if (tick && margin_lo_r && !margin_hi_r && active_code != lower_code)
      active_code <= (active_code < lower_code) ? active_code + 1'b1
                                                : active_code - 1'b1;
    else if (tick && waveform_run_bit && !margin_hi_r && !margin_lo_r)
    begin
      // Triangle walks an out-of-band code back one per step; saws jump at or past their wrap end; square alternates upper_code and lower_code
      case (waveform_shape_select)
        dac_trig_pkg::SHAPE_TRIANGLE:
          if (dir_up_r)
          begin
            if (active_code >= upper_code)
              dir_up_r <= 1'b0;
            else
              active_code <= active_code + 1'b1;
          end
          else
          begin
            if (active_code <= lower_code)
              dir_up_r <= 1'b1;
            else
              active_code <= active_code - 1'b1;
          end
        dac_trig_pkg::SHAPE_SAW_UP:
          active_code <= (active_code >= upper_code) ? lower_code : active_code + 1'b1;
        dac_trig_pkg::SHAPE_SAW_DOWN:
          active_code <= (active_code <= lower_code) ? upper_code : active_code - 1'b1;
        default:
          active_code <= (active_code == upper_code) ? lower_code : upper_code;
      endcase
    end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Code registers are write-only and read zero
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      rdata <= 16'h0000;
    else if (rd_en)
    begin
      if (addr == dac_trig_pkg::TRIG_ADDR)
        rdata <= dac_trig_pkg::TRIG_RESET |
                 (16'(margin_hi_r) << dac_trig_pkg::MARGIN_HI_BIT) |
                 (16'(margin_lo_r) << dac_trig_pkg::MARGIN_LO_BIT);
      else
        rdata <= 16'h0000;
    end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  unlock_pulse_a: assert property (wr_en && addr == dac_trig_pkg::TRIG_ADDR && wdata[15:12] == 4'h5
    |=> lock_clear && !locked) else $error("unlock key not honoured");
  lock_hold_a: assert property (wr_en && locked && addr == dac_trig_pkg::UPPER_ADDR && !store_done
    |=> $stable(upper_code)) else $error("locked write changed a register");
  cfg_reset_a: assert property (cfg_rst |=> active_code == '0 && upper_code == '0
    && !waveform_run_bit && defaults_load) else $error("config reset missed");
  run_start_a: assert property (wr_trig && wdata[8] && !defaults |=> waveform_run_bit)
    else $error("waveform run not set");
  square_step_a: assert property (tick && waveform_run_bit && !margin_hi_r && !margin_lo_r
    && waveform_shape_select == 2'h3 && active_code == upper_code && !wr_en && !store_done
    |=> active_code == lower_code) else $error("square wave did not toggle");
  margin_hi_clear_a: assert property (margin_hi_r && active_code == upper_code && !wr_en
    |=> !margin_hi_r) else $error("margin high did not clear");
  margin_lo_step_a: assert property (tick && margin_lo_r && !margin_hi_r && !wr_en && !store_done
    && active_code > lower_code |=> active_code == $past(active_code) - 1'b1)
    else $error("margin low did not step");
  recall_busy_a: assert property (recall_go |=> store_busy_flag && store_recall_trigger
    ##1 !store_recall_trigger) else $error("recall start wrong");
  save_busy_a: assert property (save_go |=> store_busy_flag && store_save_trigger
    ##1 !store_save_trigger) else $error("save start wrong");
  soft_reset_a: assert property (sw_rst && op_r == dac_trig_pkg::ST_IDLE
    |=> store_busy_flag && !waveform_run_bit) else $error("soft reset missed");
  trig_read_a: assert property (rd_en && addr == dac_trig_pkg::TRIG_ADDR
    |=> rdata[3:0] == 4'h8 && rdata[15:8] == 8'h00) else $error("trigger read wrong");
  code_write_a: assert property (wr_ok && addr == dac_trig_pkg::OUT_CODE_ADDR && !defaults
    && !(op_r == dac_trig_pkg::ST_RECALL && store_done)
    |=> active_code == $past(wdata[11 -: CODE_W])) else $error("code write lost");

  waveform_cov: cover property (waveform_run_bit && tick ##1 waveform_run_bit);
  margin_cov: cover property (margin_hi_r ##1 !margin_hi_r);
  recall_cov: cover property (recall_go ##[1:50] store_done);
  unlock_cov: cover property (locked ##1 lock_clear);
endmodule // dac_trigger_and_code_regs
`default_nettype wire

// [store_model.sv]
`default_nettype none
module store_model #(
  parameter int CODE_W = 10,
  parameter int LAT    = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              recall,
  input  wire logic              save,
  input  wire logic [CODE_W-1:0] act_in,
  input  wire logic [CODE_W-1:0] up_in,
  input  wire logic [CODE_W-1:0] lo_in,
  output logic                   done,
  output logic      [CODE_W-1:0] act_out,
  output logic      [CODE_W-1:0] up_out,
  output logic      [CODE_W-1:0] lo_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CODE_W-1:0] act_r;
  logic [CODE_W-1:0] up_r;
  logic [CODE_W-1:0] lo_r;
  logic [7:0]        cnt_r;
  logic              busy_r;
  // ---------------------------------------------
  // Slow store, done LAT+1 cycles after a start
  // ---------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      {act_r, up_r, lo_r} <= '0;
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (recall || save)
      begin
        busy_r <= 1'b1;
        cnt_r <= 8'(LAT);
        if (save)
          {act_r, up_r, lo_r} <= {act_in, up_in, lo_in};
      end
      else if (busy_r && cnt_r == 8'h00)
      begin
        busy_r <= 1'b0;
        done <= 1'b1;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 8'h01;
    end
  end
  // Codes are only valid with done, garbage otherwise
  assign act_out = done ? act_r : ~act_r;
  assign up_out  = done ? up_r : ~up_r;
  assign lo_out  = done ? lo_r : ~lo_r;
endmodule // store_model
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, reset, wr_en, rd_en, lock_in, store_done;
  logic [7:0]  addr, code8;
  logic [15:0] wdata, rdata, step_cycles;
  logic [1:0]  waveform_shape_select;
  logic [9:0]  store_out_code, store_upper_code, store_lower_code;
  logic        store_recall_trigger, store_save_trigger, store_busy_flag;
  logic        lock_clear, defaults_load, ju, jd, lock_set;
  logic [9:0]  active_code, upper_code, lower_code, mn, mx, prv;
  int          num_errors, n_tests, cycles, n_unlock, n_dflt, s;
  dac_trigger_and_code_regs dac_trigger_and_code_regs_inst (.clk_sys, .reset,
    .wr_en, .rd_en, .addr, .wdata, .rdata, .lock_in, .waveform_shape_select,
    .step_cycles, .store_done, .store_out_code, .store_upper_code,
    .store_lower_code, .store_recall_trigger, .store_save_trigger,
    .store_busy_flag, .lock_clear, .defaults_load, .active_code,
    .upper_code, .lower_code);
  // Narrow part only checks code alignment, its store is unused
  dac_trigger_and_code_regs #(.CODE_W(8)) dac_trigger_and_code_regs_narrow_inst (
    .clk_sys, .reset, .wr_en, .rd_en, .addr, .wdata, .rdata(), .lock_in,
    .waveform_shape_select, .step_cycles, .store_done(1'b0),
    .store_out_code(8'h00), .store_upper_code(8'h00), .store_lower_code(8'h00),
    .store_recall_trigger(), .store_save_trigger(), .store_busy_flag(),
    .lock_clear(), .defaults_load(), .active_code(code8), .upper_code(),
    .lower_code());
  store_model store_model_inst (.clk_sys, .reset, .recall(store_recall_trigger),
    .save(store_save_trigger), .act_in(active_code), .up_in(upper_code),
    .lo_in(lower_code), .done(store_done), .act_out(store_out_code),
    .up_out(store_upper_code), .lo_out(store_lower_code));
  // ---------------------------------------------
  // Bus tasks and checking
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk_sys);
    rd_en = 1'b0;
    check(rdata, exp);
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 100 && store_busy_flag !== lvl; i++)
      @(negedge clk_sys);
  endtask
  task automatic wait_code(input logic [9:0] t);
    for (int i = 0; i < 100 && active_code !== t; i++)
      @(negedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Stands in for the neighbour that owns the lock bit
  always @(posedge clk_sys)
  begin
    cycles++;
    if (lock_clear === 1'b1)
      n_unlock++;
    // Neighbour drops the lock on the unlock pulse, sets it on request
    if (reset || lock_clear === 1'b1)
      lock_in <= 1'b0;
    else if (lock_set)
      lock_in <= 1'b1;
    if (defaults_load === 1'b1)
      n_dflt++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    {reset, wr_en, rd_en, lock_set, addr, wdata} = {1'b1, 27'h0};
    {step_cycles, waveform_shape_select} = 18'h0;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    rd(8'hd3, 16'h0008);
    rd(8'h40, 16'h0000);
    wr(8'h21, 16'hf557);
    check(active_code, 16'h155);
    check(code8, 16'h55);
    rd(8'h21, 16'h0000);
    wr(8'h25, 16'ha079);
    wr(8'h26, 16'h0028);
    check(upper_code, 16'd30);
    check(lower_code, 16'd10);
    $display("test codes done");
    wr(8'h21, 16'h0050);
    wr(8'hd3, 16'h0088);
    rd(8'hd3, 16'h0088);
    wait_code(10'd30);
    repeat (2) @(negedge clk_sys);
    rd(8'hd3, 16'h0008);
    wr(8'hd3, 16'h0048);
    wait_code(10'd10);
    check(active_code, 16'd10);
    repeat (2) @(negedge clk_sys);
    rd(8'hd3, 16'h0008);
    $display("test margins done");
    for (s = 0; s < 4; s++)
    begin
      waveform_shape_select = s[1:0];
      wr(8'hd3, 16'h0108);
      {mn, mx, prv, ju, jd} = {10'h3ff, 10'h0, active_code, 2'b00};
      repeat (100)
      begin
        @(negedge clk_sys);
        if (active_code < mn) mn = active_code;
        if (active_code > mx) mx = active_code;
        if (active_code > prv + 10'd1) ju = 1'b1;
        if (active_code + 10'd1 < prv) jd = 1'b1;
        prv = active_code;
      end
      check({mn, mx}, {10'd10, 10'd30});
      check({ju, jd}, {s >= 2, s[0]});
    end
    wr(8'hd3, 16'h0008);
    prv = active_code;
    repeat (20) @(negedge clk_sys);
    check(active_code, prv);
    $display("test waveform done");
    wr(8'h21, 16'h02a8);
    wr(8'hd3, 16'h0018);
    wait_busy(1'b1);
    check(store_busy_flag, 1'b1);
    wait_busy(1'b0);
    wr(8'h21, 16'h00cc);
    wr(8'hd3, 16'h0028);
    wait_busy(1'b1);
    check(store_busy_flag, 1'b1);
    wait_busy(1'b0);
    @(negedge clk_sys);
    check(active_code, 16'h0aa);
    check(upper_code, 16'd30);
    $display("test store done");
    wr(8'h21, 16'h0044);
    wr(8'hd3, 16'h000a);
    wait_busy(1'b1);
    wait_busy(1'b0);
    @(negedge clk_sys);
    check(active_code, 16'h0aa);
    check(n_dflt, 1);
    wr(8'hd3, 16'h0208);
    @(negedge clk_sys);
    check({active_code, upper_code}, 20'h0);
    wr(8'hd3, 16'h0008);
    check(n_dflt, 2);
    $display("test resets done");
    lock_set = 1'b1;
    @(negedge clk_sys);
    lock_set = 1'b0;
    wr(8'h21, 16'h01dc);
    check(active_code, 16'h000);
    wr(8'hd3, 16'h5008);
    @(negedge clk_sys);
    check(n_unlock, 1);
    wr(8'h21, 16'h01dc);
    check(active_code, 16'h077);
    $display("test lock done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
